// *** common/sdms_regs.vh ***
`ifndef SDMS_REGS_VH
`define SDMS_REGS_VH

// Register byte offsets
`define SDMS_ADR_CTRL      8'h00
`define SDMS_ADR_STATUS    8'h04

// Control register fields
`define SDMS_CTRL_RES_LSB  0
`define SDMS_CTRL_RES_MSB  3
`define SDMS_CTRL_IPEN_BIT 8
`define SDMS_RES_RST       4'h0
`define SDMS_IPEN_RST      1'b1
`define SDMS_RES_MAX       4'h8

// Status register fields
`define SDMS_STAT_POS_LSB  0
`define SDMS_STAT_POS_MSB  9
`define SDMS_STAT_STST_BIT 16
`define SDMS_STAT_IDX_BIT  17
`define SDMS_STAT_DIR_BIT  18

// Standstill limit in system clock cycles, and position reset value
`define SDMS_STST_LIMIT    21'h100000
`define SDMS_POS_RST       10'h000

`endif

// *** src/sdms_sequencer.v ***
`timescale 1ns/10ps
// Contract
// - Rising step edges and coarser resolution writes move the sequencer
// - Step and direction synchronised before use
// - 1024-position sine lookup indexed by position
// - Direction low adds width, high subtracts
// - Step width doubles from 1 to 256
// - Coarser resolution snaps to nearest valid position
// - Fullstep targets 128, 384, 640, 896 only
// - Coarse grids offset by half step width
// - Microsteps spaced by last interval over width
// - Two to 256 microsteps per step pulse
// - Standstill when interval exceeds 2^20 cycles
// - Standstill flag set, cleared on next step
// - Standstill with powerdown select starts standby reduction
// - New pulse skips remaining microsteps, adopts rate
// - Index high over first quarter, positions 0 to 255
// - Position counter wraps between 1023 and 0
`include "sdms_regs.vh"

module sdms_sequencer #(
  parameter [20:0] STST_LIMIT = `SDMS_STST_LIMIT
) (
  input  wire        i_mclk,                 // System clock, 50 MHz
  input  wire        i_rst,                  // Asynchronous reset, active high
  input  wire        i_ce,                   // Clock enable, freezes state when low
  input  wire        i_step,                 // Step pulse from controller
  input  wire        i_dir,                  // Rotation sense from controller
  input  wire        i_powerdown_select_pin, // Standby reduction selected
  input  wire        i_wb_cyc,               // Wishbone cycle
  input  wire        i_wb_stb,               // Wishbone strobe
  input  wire        i_wb_we,                // Wishbone write enable
  input  wire [7:0]  i_wb_adr,               // Wishbone byte address
  input  wire [31:0] i_wb_dat,               // Wishbone write data
  input  wire [3:0]  i_wb_sel,               // Wishbone byte selects
  output reg  [31:0] o_wb_dat,               // Wishbone read data
  output reg         o_wb_ack,               // Wishbone acknowledge
  output reg  [9:0]  o_pos,                  // Microstep position count
  output reg  [9:0]  o_coil_a,               // Coil A current, signed
  output reg  [9:0]  o_coil_b,               // Coil B current, signed
  output reg         o_index,                // Electrical zero marker
  output reg         o_standstill,           // Standstill flag
  output reg         o_standby_reduce        // Start standby current reduction
);

  // Parabolic sine of a table position, 1024 entries per revolution
  function [9:0] sdms_sine;
    input [9:0] p;
    reg   [8:0] x;
    reg   [17:0] m;
    begin
      x = p[8] ? (9'h100 - {1'b0, p[7:0]}) : {1'b0, p[7:0]};
      m = {9'h000, x} * ({9'h000, 9'h1FF} - {9'h000, x} + 18'h00001);
      sdms_sine = p[9] ? (10'h000 - {1'b0, m[16:8]}) : {1'b0, m[16:8]};
    end
  endfunction

  // Nearest grid position for resolution r: grid is half width plus multiples
  function [9:0] sdms_snap;
    input [9:0] t;
    input [3:0] r;
    reg   [9:0] w;
    begin
      w = 10'h001 << r;
      sdms_snap = (t & ~(w - 10'h001)) + (w >> 1);
    end
  endfunction

  reg        step_s1;
  reg        step_s2;
  reg        step_s3;
  reg        dir_s1;
  reg        dir_s2;
  reg [3:0]  res;
  reg        ipen;
  reg [9:0]  tgt;
  reg        mdir;
  reg [8:0]  rem;
  reg [20:0] tcnt;
  reg [20:0] gap;
  reg [20:0] ucnt;

  wire       step_rise = step_s2 & ~step_s3;
  wire [9:0] stepw     = 10'h001 << res;
  wire [9:0] next_tgt  = dir_s2 ? (tgt - stepw) : (tgt + stepw);
  wire       wb_req    = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  wire       ctrl_wr   = wb_req & i_wb_we & i_wb_sel[0] & (i_wb_adr == `SDMS_ADR_CTRL);
  wire [3:0] wr_res    = (i_wb_dat[3:0] > `SDMS_RES_MAX) ? `SDMS_RES_MAX : i_wb_dat[3:0];
  wire [20:0] next_gap = tcnt >> res;

  // Two-stage synchronisers, third stage for edge detection
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      step_s1 <= 1'b0;
      step_s2 <= 1'b0;
      step_s3 <= 1'b0;
      dir_s1  <= 1'b0;
      dir_s2  <= 1'b0;
    end else if (i_ce) begin
      step_s1 <= i_step;
      step_s2 <= step_s1;
      step_s3 <= step_s2;
      dir_s1  <= i_dir;
      dir_s2  <= dir_s1;
    end
  end

  // Wishbone slave: one-cycle ack, unmapped reads return zero
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h00000000;
      res      <= `SDMS_RES_RST;
      ipen     <= `SDMS_IPEN_RST;
    end else if (i_ce) begin
      o_wb_ack <= wb_req;
      o_wb_dat <= 32'h00000000;
      if (ctrl_wr) begin
        res  <= wr_res;
        ipen <= i_wb_dat[`SDMS_CTRL_IPEN_BIT];
      end
      if (wb_req && !i_wb_we) begin
        case (i_wb_adr)
          `SDMS_ADR_CTRL: begin
            o_wb_dat[`SDMS_CTRL_RES_MSB:`SDMS_CTRL_RES_LSB] <= res;
            o_wb_dat[`SDMS_CTRL_IPEN_BIT] <= ipen;
          end
          `SDMS_ADR_STATUS: begin
            o_wb_dat[`SDMS_STAT_POS_MSB:`SDMS_STAT_POS_LSB] <= o_pos;
            o_wb_dat[`SDMS_STAT_STST_BIT] <= o_standstill;
            o_wb_dat[`SDMS_STAT_IDX_BIT]  <= o_index;
            o_wb_dat[`SDMS_STAT_DIR_BIT]  <= dir_s2;
          end
          default: begin
            o_wb_dat <= 32'h00000000;
          end
        endcase
      end
    end
  end

  // Step interval timer and standstill detection
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      tcnt         <= 21'h000000;
      o_standstill <= 1'b0;
    end else if (i_ce) begin
      if (step_rise) begin
        tcnt         <= 21'h000000;
        o_standstill <= 1'b0;
      end else begin
        if (tcnt != STST_LIMIT)
          tcnt <= tcnt + 21'h000001;
        if (tcnt == STST_LIMIT)
          o_standstill <= 1'b1;
      end
    end
  end

  // Step target and interpolated microstep position
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      tgt   <= `SDMS_POS_RST;
      o_pos <= `SDMS_POS_RST;
      mdir  <= 1'b0;
      rem   <= 9'h000;
      gap   <= 21'h000001;
      ucnt  <= 21'h000000;
    end else if (i_ce) begin
      if (ctrl_wr && wr_res > res) begin
        tgt   <= sdms_snap(tgt, wr_res);
        o_pos <= sdms_snap(tgt, wr_res);
        rem   <= 9'h000;
      end else if (step_rise) begin
        tgt  <= next_tgt;
        mdir <= dir_s2;
        ucnt <= 21'h000000;
        if (o_standstill || !ipen || res == 4'h0) begin
          o_pos <= next_tgt;
          rem   <= 9'h000;
        end else begin
          o_pos <= tgt;
          rem   <= stepw[8:0];                      // Width counts, 256 at most
          gap   <= (next_gap == 21'h000000) ? 21'h000001 : next_gap;
        end
      end else if (rem != 9'h000) begin
        if (ucnt + 21'h000001 >= gap) begin
          o_pos <= mdir ? (o_pos - 10'h001) : (o_pos + 10'h001);
          rem   <= rem - 9'h001;
          ucnt  <= 21'h000000;
        end else begin
          ucnt <= ucnt + 21'h000001;
        end
      end
    end
  end

  // Coil currents, index and standby request
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_coil_a         <= 10'h000;
      o_coil_b         <= 10'h100;
      o_index          <= 1'b1;
      o_standby_reduce <= 1'b0;
    end else if (i_ce) begin
      o_coil_a         <= sdms_sine(o_pos);
      o_coil_b         <= sdms_sine(o_pos + 10'h100);
      o_index          <= (o_pos[9:8] == 2'b00);
      o_standby_reduce <= o_standstill & i_powerdown_select_pin;
    end
  end

endmodule // sdms_sequencer

// *** verif/sdms_sequencer_assertions.sv ***
`timescale 1ns/10ps
module sdms_sequencer_assertions (
  input wire        i_mclk,                 // Clock
  input wire        i_rst,                  // Reset
  input wire        i_ce,                   // Enable
  input wire        i_step,                 // Step
  input wire        i_powerdown_select_pin, // Standby select
  input wire        i_wb_cyc,               // Cycle
  input wire        i_wb_stb,               // Strobe
  input wire [31:0] o_wb_dat,               // Read data
  input wire        o_wb_ack,               // Ack
  input wire [9:0]  o_pos,                  // Position
  input wire        o_index,                // Index
  input wire        o_standstill,           // Standstill
  input wire        o_standby_reduce        // Standby
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // Step seen low, then high
  sequence step_rise;
    !i_step ##1 i_step;
  endsequence
  a_ack_next: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack && i_ce |=> o_wb_ack)
    else $error("no ack");
  a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack held");
  a_dat_idle: assert property (!o_wb_ack |-> o_wb_dat == 32'h0) else $error("stray data");
  a_fall_still: assert property ($past(o_standstill) && !o_wb_ack && !$past(o_wb_ack)
    && !($past(i_step, 3) && !$past(i_step, 4)) |-> $stable(o_pos)) else $error("pos moved");
  a_stst_clear: assert property (step_rise ##0 o_standstill |-> ##[1:4] !o_standstill)
    else $error("standstill kept");
  a_standby_on: assert property (o_standstill && i_powerdown_select_pin |=> o_standby_reduce)
    else $error("no standby");
  a_standby_off: assert property (!o_standstill [*2] |-> !o_standby_reduce)
    else $error("stray standby");
  a_index_zone: assert property (o_index == ($past(o_pos) < 10'h100))
    else $error("index wrong");
endmodule // sdms_sequencer_assertions

bind sdms_sequencer sdms_sequencer_assertions i_chk (.*);

// *** verif/sdms_sequencer_test.sv ***
`timescale 1ns/10ps
module sdms_sequencer_test;
  logic        i_mclk, i_rst, i_ce, i_powerdown_select_pin, i_wb_cyc, i_wb_stb, i_wb_we;
  logic [7:0]  i_wb_adr;
  logic [3:0]  i_wb_sel;
  logic [31:0] i_wb_dat, o_wb_dat, rd, seed;
  logic [9:0]  o_pos, o_coil_a, o_coil_b, e;
  logic        i_step, i_dir, o_wb_ack, o_index, o_standstill, o_standby_reduce;
  int          n_fail, num_checks, r;
  sdms_step_src i_sdms_step_src (.i_mclk(i_mclk), .o_step(i_step), .o_dir(i_dir));
  sdms_sequencer #(.STST_LIMIT(21'h0000C8)) i_sdms_sequencer (.*);
  initial begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end
  // Watchdog
  initial begin
    #400000;
    n_fail++;
    end_sim();
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Nearest point of the coarser grid, half a width off zero
  function automatic logic [9:0] snap(logic [9:0] p, int k);
    return (p & ~10'((1 << k) - 1)) | 10'((1 << k) >> 1);
  endfunction
  task automatic chk(logic [31:0] got, logic [31:0] want);
    num_checks++;
    if (got !== want) begin
      n_fail++;
      $display("CHECK FAILED t=%0t value got %0h want %0h", $time, got, want);
    end
  endtask
  // One classic cycle, held until ack is sampled
  task automatic wb(logic w, logic [7:0] a, logic [31:0] v);
    @(posedge i_mclk);
    {i_wb_cyc, i_wb_stb, i_wb_sel} <= 6'h3F;
    {i_wb_we, i_wb_adr, i_wb_dat} <= {w, a, v};
    do @(posedge i_mclk); while (o_wb_ack !== 1'b1);
    rd = o_wb_dat;
    {i_wb_cyc, i_wb_stb} <= 2'h0;
  endtask
  // Direct move by one width
  task automatic step(logic [31:0] dv);
    i_sdms_step_src.pulse(dv[0], 2 + rnd() % 4);
    e = dv[0] ? e - 10'(1 << r) : e + 10'(1 << r);
    chk(o_pos, e);
  endtask
  task end_sim();
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    {i_rst, i_ce, i_powerdown_select_pin, seed, e, r} = {3'h7, 32'h11, 10'h0, 32'h0};
    {i_wb_cyc, i_wb_stb, i_wb_we, i_wb_adr, i_wb_dat, i_wb_sel} = 47'h0;
    repeat (12) @(posedge i_mclk);
    chk(o_coil_b, 32'h100);
    chk(o_coil_a, 32'h0);
    chk(o_index, 1'b1);
    i_rst <= 1'b0;
    wb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h100);
    wb(1'b0, 8'h0C, 32'h0);
    chk(rd, 32'h0);
    wb(1'b1, 8'h00, 32'h0);
    step(1);
    // Each resolution coarser than the last, random directions
    for (r = 0; r <= 8; r++) begin
      wb(1'b1, 8'h00, r);
      e = snap(e, r);
      repeat (2) @(posedge i_mclk);
      chk(o_pos, e);
      repeat (6) step(rnd());
    end
    // Fullstep grid: both coils at equal magnitude, index over first quarter
    @(posedge i_mclk);
    chk(10'(o_coil_a[9] ? -o_coil_a : o_coil_a), 10'(o_coil_b[9] ? -o_coil_b : o_coil_b));
    chk(o_index, e < 10'h100);
    // Finer width 8 with interpolation: no move, then standstill
    r = 3;
    wb(1'b1, 8'h00, 32'h103);
    repeat (250) @(posedge i_mclk);
    chk(o_pos, e);
    chk(o_standstill, 1'b1);
    chk(o_standby_reduce, 1'b1);
    wb(1'b0, 8'h04, 32'h0);
    chk(rd[9:0], e);
    chk(rd[16], 1'b1);
    step(0);
    chk(o_standstill, 1'b0);
    repeat (75) @(posedge i_mclk);
    i_sdms_step_src.pulse(1'b0, 2);
    repeat (30) @(posedge i_mclk);
    chk(10'(o_pos - e) inside {[10'h1:10'h7]}, 1'b1);
    i_sdms_step_src.pulse(1'b0, 2);
    repeat (100) @(posedge i_mclk);
    chk(o_pos, e + 10'h10);
    end_sim();
  end
endmodule // sdms_sequencer_test

// *** verif/sdms_step_src.sv ***
`timescale 1ns/10ps
// Motion controller model: drives step pulses and rotation sense
module sdms_step_src (
  input  wire i_mclk, // System clock
  output reg  o_step, // Step pulse
  output reg  o_dir   // Rotation sense
);
  initial o_step = 1'b0;
  initial o_dir = 1'b0;
  // Sense settles a cycle ahead; high and low last two cycles or more
  task pulse(input logic d, input int hi);
    @(posedge i_mclk) o_dir <= d;
    @(posedge i_mclk) o_step <= 1'b1;
    repeat (hi) @(posedge i_mclk);
    o_step <= 1'b0;
    repeat (2) @(posedge i_mclk);
  endtask
endmodule // sdms_step_src
